// ### verilog/lpsd_defines.vh
`ifndef LPSD_DEFINES_VH
`define LPSD_DEFINES_VH
// ----------------------------------------
// Command codes {ras_n, cas_n, we_n}
// ----------------------------------------
`define LPSD_CMD_NOP 3'h7
`define LPSD_CMD_ACT 3'h3
`define LPSD_CMD_RD 3'h5
`define LPSD_CMD_WR 3'h4
`define LPSD_CMD_PRE 3'h2
`define LPSD_CMD_BST 3'h6
`define LPSD_CMD_REF 3'h1
`define LPSD_CMD_MRS 3'h0
// ----------------------------------------
// Power / init states
// ----------------------------------------
`define LPSD_PW_UNINIT 3'h0
`define LPSD_PW_RUN 3'h1
`define LPSD_PW_APD 3'h2
`define LPSD_PW_PPD 3'h3
`define LPSD_PW_SREF 3'h4
`define LPSD_PW_DEEP 3'h5
// Bank states
`define LPSD_BK_IDLE 3'h0
`define LPSD_BK_ACTV 3'h1
`define LPSD_BK_OPEN 3'h2
`define LPSD_BK_RD 3'h3
`define LPSD_BK_WR 3'h4
`define LPSD_BK_PRE 3'h5
// ----------------------------------------
// Timing in cycles at 10 MHz (100 ns)
// ----------------------------------------
`define LPSD_CLK_NS 100
`define LPSD_TRP_NS 15
`define LPSD_ACT_TO_COL_TIME_NS 15
`define LPSD_TWR_NS 15
`define LPSD_REFRESH_CYCLE_TIME_NS 110
`define LPSD_MODE_LOAD_TIME_CK 2
`define LPSD_TRP_CK ((`LPSD_TRP_NS + `LPSD_CLK_NS - 1) / `LPSD_CLK_NS)
`define LPSD_ACT_TO_COL_TIME_CK ((`LPSD_ACT_TO_COL_TIME_NS + `LPSD_CLK_NS - 1) / `LPSD_CLK_NS)
`define LPSD_TWR_CK ((`LPSD_TWR_NS + `LPSD_CLK_NS - 1) / `LPSD_CLK_NS)
`define LPSD_REFRESH_CYCLE_TIME_CK ((`LPSD_REFRESH_CYCLE_TIME_NS + `LPSD_CLK_NS - 1) / `LPSD_CLK_NS)
`define LPSD_INIT_US 200
`define LPSD_INIT_CK (`LPSD_INIT_US * 1000 / `LPSD_CLK_NS)
// Burst length 4 gives half-burst of 2 cycles
`define LPSD_HALF_BL 2
`define LPSD_AP_BIT 10
// ----------------------------------------
// Synchroniser word {cke, cs_n, ras_n, cas_n, we_n, bank_addr, addr}
// ----------------------------------------
`define LPSD_PIN_W 20
`define LPSD_PIN_CKE 19
`define LPSD_PIN_SEL 18
`define LPSD_PIN_CMD 17:15
`define LPSD_PIN_BA 14:13
`define LPSD_TW 5
`endif

// ### verilog/lpsd_core.v
`include "lpsd_defines.vh"
`default_nettype none
// What this block does
// - Commands to other banks are taken while one bank is busy.
// - Idle after precharge time; row active after activate-to-column time.
// - Read auto precharge starts at the earliest legal precharge point.
// - Write auto precharge starts when write recovery ends.
// - Other-bank commands accepted during auto precharge.
// - Clock enable low twice holds state; low then high with NOP exits.
// - Clock enable falling enters power-down, self refresh or deep sleep.
// - Decision uses state before the edge and command at that edge.
// - Initialization with clock enable high or rising before first command.
// - Commands decoded from active-low select and strobes.
// - Burst stop acts on the latest read burst in any bank.
module lpsd_core #(
    parameter INIT_CYCLES = `LPSD_INIT_CK
) (
    input wire clk,
    input wire rstn,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [1:0] bank_addr,
    input wire [12:0] addr,
    output reg [2:0] power_state,
    output reg ready,
    output wire [11:0] bank_states,
    output reg illegal_cmd,
    output reg read_burst_active,
    output reg write_burst_active
);
// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [`LPSD_PIN_W-1:0] pin_s1;
reg [`LPSD_PIN_W-1:0] pin_s2;
// All ones reads as deselect with clock enable high, so reset looks idle
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pin_s1 <= {`LPSD_PIN_W{1'b1}};
        pin_s2 <= {`LPSD_PIN_W{1'b1}};
    end else begin
        pin_s1 <= {cke, cs_n, ras_n, cas_n, we_n, bank_addr, addr};
        pin_s2 <= pin_s1;
    end
end
wire cke_now = pin_s2[`LPSD_PIN_CKE];
wire sel_n = pin_s2[`LPSD_PIN_SEL];
wire [2:0] code = pin_s2[`LPSD_PIN_CMD];
wire [1:0] ba = pin_s2[`LPSD_PIN_BA];
wire ap = pin_s2[`LPSD_AP_BIT];
// Cycle counts as integers, cut to counter width where loaded
localparam integer TRP_CK = `LPSD_TRP_CK;
localparam integer ACT_TO_COL_TIME_CK = `LPSD_ACT_TO_COL_TIME_CK;
localparam integer REFRESH_CYCLE_TIME_CK = `LPSD_REFRESH_CYCLE_TIME_CK;
localparam integer MODE_LOAD_TIME_CK = `LPSD_MODE_LOAD_TIME_CK;
localparam integer RD_HOLD = `LPSD_HALF_BL;
localparam integer WR_HOLD = `LPSD_HALF_BL + `LPSD_TWR_CK;
reg cke_prev;
function [2:0] lpsd_dec;
    input s_n;
    input [2:0] c;
    begin
        lpsd_dec = s_n ? `LPSD_CMD_NOP : c;
    end
endfunction
wire [2:0] cmd = lpsd_dec(sel_n, code);
wire is_nop = (cmd == `LPSD_CMD_NOP);
wire run_edge = cke_prev && cke_now && (power_state == `LPSD_PW_RUN);
// ----------------------------------------
// Init sequence tracking
// ----------------------------------------
reg [15:0] init_cnt;
reg [1:0] ref_seen;
reg mrs_std;
reg mrs_ext;
reg init_pre_done;
reg [2:0] next_power;
reg all_idle;
integer k;
always @* begin
    all_idle = 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
        if (bank_states[k*3 +: 3] != `LPSD_BK_IDLE)
            all_idle = 1'b0;
    end
end
reg [5:0] glob_cnt;
wire glob_busy = (glob_cnt != 6'h00);
// decided from the state before this edge
always @* begin
    next_power = power_state;
    case (power_state)
        `LPSD_PW_RUN: begin
            if (cke_prev && !cke_now) begin
                if (!all_idle && is_nop)
                    next_power = `LPSD_PW_APD;
                else if (all_idle && is_nop)
                    next_power = `LPSD_PW_PPD;
                else if (all_idle && cmd == `LPSD_CMD_REF)
                    next_power = `LPSD_PW_SREF;
                else if (all_idle && cmd == `LPSD_CMD_BST)
                    next_power = `LPSD_PW_DEEP;
            end
        end
        `LPSD_PW_APD, `LPSD_PW_PPD, `LPSD_PW_SREF: begin
            if (!cke_prev && cke_now && is_nop)
                next_power = `LPSD_PW_RUN;
        end
        `LPSD_PW_DEEP: begin
            // Mode registers are lost, so a fresh init follows
            if (!cke_prev && cke_now && is_nop)
                next_power = `LPSD_PW_UNINIT;
        end
        `LPSD_PW_UNINIT: begin
            if (mrs_std && mrs_ext && !glob_busy)
                next_power = `LPSD_PW_RUN;
        end
        default: next_power = `LPSD_PW_UNINIT;
    endcase
end
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        cke_prev <= 1'b0;
        power_state <= `LPSD_PW_UNINIT;
        ready <= 1'b0;
        init_cnt <= 16'h0000;
        ref_seen <= 2'h0;
        mrs_std <= 1'b0;
        mrs_ext <= 1'b0;
        init_pre_done <= 1'b0;
        glob_cnt <= 6'h00;
        illegal_cmd <= 1'b0;
    end else begin
        cke_prev <= cke_now;
        power_state <= next_power;
        ready <= (next_power == `LPSD_PW_RUN);
        illegal_cmd <= 1'b0;
        if (glob_busy)
            glob_cnt <= glob_cnt - 6'h01;
        if (power_state == `LPSD_PW_DEEP) begin
            init_cnt <= 16'h0000;
            ref_seen <= 2'h0;
            mrs_std <= 1'b0;
            mrs_ext <= 1'b0;
            init_pre_done <= 1'b0;
        end else if (power_state == `LPSD_PW_UNINIT && cke_now) begin
            // counting starts once clock enable is high
            if (init_cnt != INIT_CYCLES[15:0])
                init_cnt <= init_cnt + 16'h0001;
            if (!is_nop && (init_cnt != INIT_CYCLES[15:0] || glob_busy))
                illegal_cmd <= 1'b1;
            else if (cmd == `LPSD_CMD_PRE && ap) begin
                init_pre_done <= 1'b1;
                glob_cnt <= TRP_CK[5:0];
            end else if (cmd == `LPSD_CMD_REF && init_pre_done) begin
                if (ref_seen != 2'h2)
                    ref_seen <= ref_seen + 2'h1;
                glob_cnt <= REFRESH_CYCLE_TIME_CK[5:0];
            end else if (cmd == `LPSD_CMD_MRS && ref_seen == 2'h2) begin
                if (ba[1])
                    mrs_ext <= 1'b1;
                else
                    mrs_std <= 1'b1;
                glob_cnt <= MODE_LOAD_TIME_CK[5:0];
            end else if (!is_nop)
                illegal_cmd <= 1'b1;
        end else if (run_edge) begin
            if ((cmd == `LPSD_CMD_REF) || (cmd == `LPSD_CMD_MRS)) begin
                if (!all_idle || glob_busy)
                    illegal_cmd <= 1'b1;
                glob_cnt <= (cmd == `LPSD_CMD_REF) ?
                    REFRESH_CYCLE_TIME_CK[5:0] : MODE_LOAD_TIME_CK[5:0];
            end else if (!is_nop && glob_busy)
                illegal_cmd <= 1'b1;
        end
    end
end
// ----------------------------------------
// Per-bank state and timers
// ----------------------------------------
reg [1:0] last_rd_bank;
reg last_rd_live;
genvar g;
generate
for (g = 0; g < 4; g = g + 1) begin : bank
    reg [2:0] st;
    reg [4:0] tmr;
    reg auto_pre;
    localparam integer BANK_NUM = g;
    wire hit = run_edge && (ba == BANK_NUM[1:0]) && !glob_busy;
    // A finished burst must not reopen its bank on a late burst stop
    wire stop = run_edge && cmd == `LPSD_CMD_BST && last_rd_live &&
        last_rd_bank == BANK_NUM[1:0] && st == `LPSD_BK_RD;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= `LPSD_BK_IDLE;
            tmr <= 5'h00;
            auto_pre <= 1'b0;
        end else if (run_edge && cmd == `LPSD_CMD_PRE && ap) begin
            st <= `LPSD_BK_PRE;
            tmr <= TRP_CK[4:0];
            auto_pre <= 1'b0;
        end else if (stop) begin
            st <= `LPSD_BK_OPEN;
            tmr <= 5'h00;
        end else if (hit && cmd == `LPSD_CMD_ACT &&
                st == `LPSD_BK_IDLE) begin
            st <= `LPSD_BK_ACTV;
            tmr <= ACT_TO_COL_TIME_CK[4:0];
        end else if (hit && (cmd == `LPSD_CMD_RD ||
                cmd == `LPSD_CMD_WR) && st != `LPSD_BK_IDLE &&
                st != `LPSD_BK_ACTV && st != `LPSD_BK_PRE) begin
            st <= (cmd == `LPSD_CMD_RD) ? `LPSD_BK_RD : `LPSD_BK_WR;
            // read precharge at burst end; write adds recovery
            tmr <= (cmd == `LPSD_CMD_RD) ? RD_HOLD[4:0] :
                WR_HOLD[4:0];
            auto_pre <= ap;
        end else if (hit && cmd == `LPSD_CMD_PRE &&
                st != `LPSD_BK_ACTV) begin
            st <= `LPSD_BK_PRE;
            tmr <= TRP_CK[4:0];
        end else if (tmr > 5'h01) begin
            tmr <= tmr - 5'h01;
        end else if (tmr == 5'h01) begin
            tmr <= 5'h00;
            case (st)
                `LPSD_BK_PRE: st <= `LPSD_BK_IDLE;
                `LPSD_BK_ACTV: st <= `LPSD_BK_OPEN;
                `LPSD_BK_RD, `LPSD_BK_WR: begin
                    if (auto_pre) begin
                        st <= `LPSD_BK_PRE;
                        tmr <= TRP_CK[4:0];
                        auto_pre <= 1'b0;
                    end else
                        st <= `LPSD_BK_OPEN;
                end
                default: st <= st;
            endcase
        end
    end
    assign bank_states[g*3 +: 3] = st;
end
endgenerate
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        last_rd_bank <= 2'h0;
        last_rd_live <= 1'b0;
        read_burst_active <= 1'b0;
        write_burst_active <= 1'b0;
    end else begin
        if (run_edge && cmd == `LPSD_CMD_RD && !glob_busy) begin
            last_rd_bank <= ba;
            last_rd_live <= 1'b1;
        end else if (run_edge && cmd == `LPSD_CMD_BST)
            last_rd_live <= 1'b0;
        read_burst_active <= (bank_states[2:0] == `LPSD_BK_RD) ||
            (bank_states[5:3] == `LPSD_BK_RD) ||
            (bank_states[8:6] == `LPSD_BK_RD) ||
            (bank_states[11:9] == `LPSD_BK_RD);
        write_burst_active <= (bank_states[2:0] == `LPSD_BK_WR) ||
            (bank_states[5:3] == `LPSD_BK_WR) ||
            (bank_states[8:6] == `LPSD_BK_WR) ||
            (bank_states[11:9] == `LPSD_BK_WR);
    end
end
endmodule
`default_nettype wire

// ### verification/lpsd_core_sva.sv
`default_nettype none
module lpsd_core_sva #(
    parameter INIT_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank_addr,
    input wire logic [12:0] addr,
    input wire logic [2:0] power_state,
    input wire logic ready,
    input wire logic [11:0] bank_states,
    input wire logic illegal_cmd,
    input wire logic read_burst_active,
    input wire logic write_burst_active
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire nop = cs_n || cmd == 4'h7;
    wire rd_any = bank_states[2:0] == 3'h3 || bank_states[5:3] == 3'h3 ||
        bank_states[8:6] == 3'h3 || bank_states[11:9] == 3'h3;
    logic cke_d;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cke_d <= 1'b1;
        end else begin
            cke_d <= cke;
        end
    end
    wire on = cke_d && !cke && power_state == 3'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_ready_run: assert property ((power_state == 3'h1) [*2] |-> ready)
        else $error("ready low while running");
    a_ready_state: assert property (ready |-> power_state == 3'h1 ||
        $past(power_state) == 3'h1) else $error("ready outside run");
    a_read_flag: assert property (read_burst_active |-> rd_any ||
        $past(rd_any)) else $error("read flag without read bank");
    a_pd_hold: assert property ((!cke) [*6] |=> $stable(power_state))
        else $error("power state moved with clock enable low");
    a_ppd_entry: assert property (on && nop && bank_states == 12'h000 |->
        ##[2:5] power_state == 3'h3) else $error("no precharge power-down");
    a_apd_entry: assert property (on && nop && bank_states != 12'h000 |->
        ##[2:5] power_state == 3'h2) else $error("no active power-down");
    a_sref_entry: assert property (on && cmd == 4'h1 |->
        ##[2:5] power_state == 3'h4) else $error("no self refresh");
    a_deep_entry: assert property (on && cmd == 4'h6 |->
        ##[2:5] power_state == 3'h5) else $error("no deep sleep");
    a_pd_exit: assert property ($rose(cke) && nop && power_state inside
        {3'h2, 3'h3, 3'h4} |-> ##[2:5] power_state == 3'h1)
        else $error("no power-down exit");
    a_deep_exit: assert property ($rose(cke) && power_state == 3'h5 |->
        !ready [*8]) else $error("ready after deep sleep exit");
    c_ppd: cover property (power_state == 3'h3);
    c_sref: cover property (power_state == 3'h4);
    c_deep: cover property (power_state == 3'h5);
endmodule
bind lpsd_core lpsd_core_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
    .clk(clk), .rstn(rstn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr),
    .power_state(power_state), .ready(ready), .bank_states(bank_states),
    .illegal_cmd(illegal_cmd), .read_burst_active(read_burst_active),
    .write_burst_active(write_burst_active));
`default_nettype wire

// ### verification/lpsd_ctrl_model.sv
`default_nettype none
module lpsd_ctrl_model (
    input wire logic clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] bank_addr,
    output logic [12:0] addr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
        bank_addr = 2'h0;
        addr = 13'h0000;
    end
    // One command edge, then deselect; address is scrambled once released
    task automatic issue(input logic [2:0] c, input logic [1:0] ba,
                         input logic a10, input logic k);
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= {1'b0, c};
        cke <= k;
        bank_addr <= ba;
        addr <= {2'h0, a10, 10'h000};
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'hF;
        addr <= ~addr;
    endtask
    task automatic init_seq(input int wait_cyc);
        repeat (wait_cyc) @(posedge clk);
        issue(3'h2, 2'h0, 1'b1, 1'b1);
        repeat (3) @(posedge clk);
        issue(3'h1, 2'h0, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        issue(3'h1, 2'h0, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        issue(3'h0, 2'h2, 1'b0, 1'b1);
        repeat (3) @(posedge clk);
        issue(3'h0, 2'h0, 1'b0, 1'b1);
        repeat (3) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INIT = 20;
    logic clk, rstn, cke, cs_n, ras_n, cas_n, we_n, ready, ill, rd_act, wr_act;
    logic [1:0] bank_addr;
    logic [12:0] addr;
    logic [2:0] power_state;
    logic [11:0] bank_states;
    wire [2:0] evt = {wr_act, rd_act, ill};
    int n_fail = 0;
    int tests_run = 0;
    lpsd_ctrl_model u_ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr));
    lpsd_core #(.INIT_CYCLES(INIT)) i_dut (.clk(clk), .rstn(rstn), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_addr(bank_addr), .addr(addr), .power_state(power_state),
        .ready(ready), .bank_states(bank_states), .illegal_cmd(ill),
        .read_burst_active(rd_act), .write_burst_active(wr_act));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Pins lag two edges and state one more, so four edges always settle
    task automatic settle();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic saw(input int sel, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (6) begin
            @(negedge clk);
            seen = seen | evt[sel];
        end
        chk(seen, exp);
    endtask
    task automatic t_init();
        chk(ready, 1'b0);
        u_ctl.issue(3'h3, 2'h0, 1'b0, 1'b1);
        saw(0, 1'b1);
        u_ctl.init_seq(INIT + 10);
        settle();
        chk(ready, 1'b1);
        chk(power_state, 12'h001);
        $display("t_init done");
    endtask
    task automatic t_banks();
        u_ctl.issue(3'h3, 2'h0, 1'b0, 1'b1);
        u_ctl.issue(3'h3, 2'h1, 1'b0, 1'b1);
        settle();
        chk(bank_states, 12'h012);
        u_ctl.issue(3'h5, 2'h0, 1'b1, 1'b1);
        saw(1, 1'b1);
        u_ctl.issue(3'h4, 2'h1, 1'b1, 1'b1);
        saw(2, 1'b1);
        settle();
        chk(bank_states, 12'h000);
        $display("t_banks done");
    endtask
    task automatic t_refresh();
        u_ctl.issue(3'h1, 2'h0, 1'b0, 1'b1);
        u_ctl.issue(3'h3, 2'h2, 1'b0, 1'b1);
        saw(0, 1'b1);
        settle();
        $display("t_refresh done");
    endtask
    task automatic t_apd();
        u_ctl.issue(3'h3, 2'h3, 1'b0, 1'b1);
        settle();
        u_ctl.issue(3'h7, 2'h0, 1'b0, 1'b0);
        settle();
        chk(power_state, 12'h002);
        u_ctl.issue(3'h7, 2'h0, 1'b0, 1'b1);
        settle();
        chk(power_state, 12'h001);
        u_ctl.issue(3'h2, 2'h3, 1'b0, 1'b1);
        settle();
        chk(bank_states, 12'h000);
        $display("t_apd done");
    endtask
    task automatic t_power();
        logic [2:0] c [3] = '{3'h7, 3'h1, 3'h6};
        for (int i = 0; i < 3; i++) begin
            u_ctl.issue(c[i], 2'h0, 1'b0, 1'b0);
            settle();
            chk(power_state, 12'(3 + i));
            settle();
            chk(power_state, 12'(3 + i));
            u_ctl.issue(3'h7, 2'h0, 1'b0, 1'b1);
            settle();
            chk(ready, i < 2);
        end
        u_ctl.init_seq(INIT + 10);
        settle();
        chk(ready, 1'b1);
        $display("t_power done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Whole run is under a thousand cycles; this margin only catches a hang
    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        $display("ERROR %0t: timeout", $time);
        summarize();
    end
    initial begin
        rstn = 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_init();
        t_banks();
        t_refresh();
        t_apd();
        t_power();
        summarize();
    end
endmodule
`default_nettype wire
